// ==== logic/dewq_pkg.sv ====
`default_nettype none
package dewq_pkg;
  localparam int ADDR_W       = 32;
  localparam int ID_W         = 4;
  localparam int TYPE_W       = 4;
  localparam int LEN_W        = 8;
  localparam int NUM_RANGES   = 2;
  localparam int RANGE_IDX_W  = 1;
  // Bus width select: 0 = 16-bit bus, 1 = 32-bit bus
  localparam logic [1:0] QBYTES_16 = 2'h2;
  localparam logic [2:0] QBYTES_32 = 3'h4;
  localparam logic [1:0] ALIGN_MASK_16 = 2'h1;
  localparam logic [1:0] ALIGN_MASK_32 = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h0000_0000;
  localparam logic [LEN_W-1:0]  LEN_ZERO  = 8'h00;
  localparam logic [ID_W-1:0]   ID_ZERO   = 4'h0;
  localparam logic [TYPE_W-1:0] TYPE_ZERO = 4'h0;
  typedef enum logic [1:0]
  {
    DEWQ_RESP_OKAY = 2'h0,
    DEWQ_RESP_ERR  = 2'h2
  } dewq_resp_type;
  typedef enum logic [2:0]
  {
    DEWQ_IDLE = 3'h1,
    DEWQ_RESP = 3'h2,
    DEWQ_HOLD = 3'h4
  } dewq_state_type;
endpackage : dewq_pkg
`default_nettype wire

// ==== logic/dewq_range_match.sv ====
`default_nettype none
module dewq_range_match
(
  input  wire logic                          ecc_enable_in,
  input  wire logic [dewq_pkg::NUM_RANGES-1:0] range_enable_in,
  input  wire logic [dewq_pkg::NUM_RANGES*dewq_pkg::ADDR_W-1:0] range_lo_in,
  input  wire logic [dewq_pkg::NUM_RANGES*dewq_pkg::ADDR_W-1:0] range_hi_in,
  input  wire logic [dewq_pkg::ADDR_W-1:0]   addr_in,
  output logic                               protected_out
);
  // Combinational range test; inclusive low and high bounds
  always_comb
  begin
    protected_out = 1'b0;
    for (int i = 0; i < dewq_pkg::NUM_RANGES; i++)
    begin
      if (ecc_enable_in && range_enable_in[i]
          && addr_in >= range_lo_in[i*dewq_pkg::ADDR_W +: dewq_pkg::ADDR_W]
          && addr_in <= range_hi_in[i*dewq_pkg::ADDR_W +: dewq_pkg::ADDR_W])
      begin
        protected_out = 1'b1;
      end
    end
  end
endmodule // dewq_range_match
`default_nettype wire

// ==== logic/dewq_checker.sv ====
`default_nettype none
module dewq_checker
(
  input  wire logic                           clk_in,
  input  wire logic                           resetn_in,
  input  wire logic                           bus32_in,
  input  wire logic                           ecc_enable_in,
  input  wire logic [dewq_pkg::NUM_RANGES-1:0] range_enable_in,
  input  wire logic [dewq_pkg::NUM_RANGES*dewq_pkg::ADDR_W-1:0] range_lo_in,
  input  wire logic [dewq_pkg::NUM_RANGES*dewq_pkg::ADDR_W-1:0] range_hi_in,
  input  wire logic                           wr_valid_in,
  output logic                                wr_ready_out,
  input  wire logic [dewq_pkg::ADDR_W-1:0]    wr_addr_in,
  input  wire logic [dewq_pkg::LEN_W-1:0]     wr_bytes_in,
  input  wire logic [dewq_pkg::ID_W-1:0]      wr_id_in,
  input  wire logic [dewq_pkg::TYPE_W-1:0]    wr_type_in,
  output logic                                resp_valid_out,
  input  wire logic                           resp_ready_in,
  output logic [1:0]                          resp_code_out,
  output logic [dewq_pkg::ID_W-1:0]           resp_id_out,
  input  wire logic                           irq_clear_in,
  output logic                                irq_out,
  output logic                                log_valid_out,
  output logic [dewq_pkg::ID_W-1:0]           log_id_out,
  output logic [dewq_pkg::TYPE_W-1:0]         log_type_out
);
  dewq_pkg::dewq_state_type state;
  dewq_pkg::dewq_state_type next_state;
  logic                     prot;
  logic                     illegal;
  logic                     accept;
  logic [1:0]               resp_code;
  logic [1:0]               next_resp_code;
  logic [dewq_pkg::ID_W-1:0] resp_id;
  logic [dewq_pkg::ID_W-1:0] next_resp_id;
  logic                     irq;
  logic                     next_irq;
  logic                     log_valid;
  logic                     next_log_valid;
  logic [dewq_pkg::ID_W-1:0] log_id;
  logic [dewq_pkg::ID_W-1:0] next_log_id;
  logic [dewq_pkg::TYPE_W-1:0] log_type;
  logic [dewq_pkg::TYPE_W-1:0] next_log_type;

  // Quantum legality of a write, given bus width
  function automatic logic quanta_ok
  (
    input logic                        b32,
    input logic [dewq_pkg::ADDR_W-1:0] a,
    input logic [dewq_pkg::LEN_W-1:0]  n
  );
    logic [1:0] m;
    m = b32 ? dewq_pkg::ALIGN_MASK_32 : dewq_pkg::ALIGN_MASK_16;
    quanta_ok = ((a[1:0] & m) == 2'h0) && ((n[1:0] & m) == 2'h0)
                && (n != dewq_pkg::LEN_ZERO);
  endfunction

  dewq_range_match u_dewq_range_match
  (
    .ecc_enable_in   (ecc_enable_in),
    .range_enable_in (range_enable_in),
    .range_lo_in     (range_lo_in),
    .range_hi_in     (range_hi_in),
    .addr_in         (wr_addr_in),
    .protected_out   (prot)
  );

  // Only protected writes are checked; others always legal
  assign illegal = prot
    && !quanta_ok(bus32_in, wr_addr_in, wr_bytes_in);
  // One write in flight; ready only while idle
  assign wr_ready_out = (state == dewq_pkg::DEWQ_IDLE);
  assign accept = wr_valid_in && wr_ready_out;
  assign resp_valid_out = (state == dewq_pkg::DEWQ_RESP);
  assign resp_code_out = resp_code;
  assign resp_id_out = resp_id;
  assign irq_out = irq;
  assign log_valid_out = log_valid;
  assign log_id_out = log_id;
  assign log_type_out = log_type;

  always_comb
  begin
    next_state = state;
    next_resp_code = resp_code;
    next_resp_id = resp_id;
    case (state)
      dewq_pkg::DEWQ_IDLE:
      begin
        if (accept)
        begin
          next_state = dewq_pkg::DEWQ_RESP;
          next_resp_id = wr_id_in;
          next_resp_code = illegal ? dewq_pkg::DEWQ_RESP_ERR
                                   : dewq_pkg::DEWQ_RESP_OKAY;
        end
      end
      dewq_pkg::DEWQ_RESP:
      begin
        if (resp_ready_in)
        begin
          next_state = dewq_pkg::DEWQ_IDLE;
        end
      end
      default:
      begin
        next_state = dewq_pkg::DEWQ_IDLE;
      end
    endcase
  end

  always_comb
  begin
    next_irq = irq;
    next_log_valid = log_valid;
    next_log_id = log_id;
    next_log_type = log_type;
    if (irq_clear_in)
    begin
      next_irq = 1'b0;
    end
    // Set wins over a same-cycle clear
    if (accept && illegal)
    begin
      next_irq = 1'b1;
      next_log_valid = 1'b1;
      next_log_id = wr_id_in;
      next_log_type = wr_type_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      state <= dewq_pkg::DEWQ_IDLE;
      resp_code <= dewq_pkg::DEWQ_RESP_OKAY;
      resp_id <= dewq_pkg::ID_ZERO;
      irq <= 1'b0;
      log_valid <= 1'b0;
      log_id <= dewq_pkg::ID_ZERO;
      log_type <= dewq_pkg::TYPE_ZERO;
    end
    else
    begin
      state <= next_state;
      resp_code <= next_resp_code;
      resp_id <= next_resp_id;
      irq <= next_irq;
      log_valid <= next_log_valid;
      log_id <= next_log_id;
      log_type <= next_log_type;
    end
  end

  sequence s_bad_write;
    accept && illegal;
  endsequence

  // Response held back by a slow initiator
  sequence s_resp_stall;
    resp_valid_out && !resp_ready_in;
  endsequence

  AST_ERR_RESP: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    s_bad_write |=> resp_valid_out && resp_code_out == dewq_pkg::DEWQ_RESP_ERR
                    && resp_id_out == $past(wr_id_in))
    else $error("illegal write not answered with error");
  AST_OK_RESP: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    accept && !illegal |=> resp_code_out == dewq_pkg::DEWQ_RESP_OKAY)
    else $error("legal write answered with error");
  AST_IRQ_SET: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    s_bad_write |=> irq_out)
    else $error("irq not raised on illegal write");
  AST_IRQ_CAUSE: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    $rose(irq_out) |-> $past(accept && illegal))
    else $error("irq rose without illegal write");
  AST_IRQ_HOLD: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    irq_out && !irq_clear_in |=> irq_out)
    else $error("irq dropped without clear");
  AST_IRQ_CLEAR: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    irq_clear_in && !(accept && illegal) |=> !irq_out)
    else $error("irq not cleared");
  AST_LOG: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    s_bad_write |=> log_id_out == $past(wr_id_in)
                    && log_type_out == $past(wr_type_in))
    else $error("violation not logged");
  AST_LOG_HOLD: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !(accept && illegal) |=> $stable(log_id_out) && $stable(log_type_out)
                             && $stable(log_valid_out))
    else $error("log changed without violation");
  AST_RESP_HOLD: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    s_resp_stall |=> resp_valid_out && $stable(resp_code_out)
                     && $stable(resp_id_out))
    else $error("response changed before handshake");
  AST_UNPROT: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    accept && !prot |=> resp_code_out == dewq_pkg::DEWQ_RESP_OKAY
                        && irq_out == $past(irq_out && !irq_clear_in))
    else $error("unprotected write flagged");
  AST_ECC_OFF: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !ecc_enable_in |-> !illegal)
    else $error("check active with ecc off");
  AST_MISALIGN: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    prot && bus32_in && wr_addr_in[1:0] != 2'h0 |-> illegal)
    else $error("misaligned protected write passed");
  AST_BAD16: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    prot && !bus32_in && (wr_addr_in[0] || wr_bytes_in[0]) |-> illegal)
    else $error("odd protected write passed on 16-bit bus");
  AST_ZERO_LEN: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    prot && wr_bytes_in == dewq_pkg::LEN_ZERO |-> illegal)
    else $error("empty protected write passed");
endmodule // dewq_checker
`default_nettype wire

// ==== tb/dewq_init_model.sv ====
`default_nettype none
module dewq_init_model
(
  input  wire logic        clk_in,
  input  wire logic        wr_ready_in,
  input  wire logic        resp_valid_in,
  input  wire logic [1:0]  resp_code_in,
  input  wire logic [3:0]  resp_id_in,
  output logic             wr_valid_out,
  output logic [31:0]      wr_addr_out,
  output logic [7:0]       wr_bytes_out,
  output logic [3:0]       wr_id_out,
  output logic [3:0]       wr_type_out,
  output logic             resp_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    wr_valid_out = 1'b0;
    wr_addr_out = 32'h0;
    wr_bytes_out = 8'h0;
    wr_id_out = 4'h0;
    wr_type_out = 4'h0;
    resp_ready_out = 1'b0;
  end
  // Stall delays the response handshake, as a slow initiator would
  task automatic write(input logic [31:0] a, input logic [7:0] n,
    input logic [3:0] id, input logic [3:0] t, input int stall,
    output logic [1:0] code, output logic [3:0] rid);
    @(posedge clk_in);
    wr_valid_out <= 1'b1;
    wr_addr_out <= a;
    wr_bytes_out <= n;
    wr_id_out <= id;
    wr_type_out <= t;
    @(posedge clk_in);
    while (wr_ready_in !== 1'b1) @(posedge clk_in);
    wr_valid_out <= 1'b0;
    // Released address and byte count scrambled so stale values cannot pass
    wr_addr_out <= ~a;
    wr_bytes_out <= ~n;
    repeat (stall) @(posedge clk_in);
    resp_ready_out <= 1'b1;
    @(posedge clk_in);
    while (resp_valid_in !== 1'b1) @(posedge clk_in);
    code = resp_code_in;
    rid = resp_id_in;
    resp_ready_out <= 1'b0;
  endtask
endmodule // dewq_init_model
`default_nettype wire

// ==== tb/test_dewq_checker.sv ====
`default_nettype none
module test_dewq_checker;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        bus32 = 1'b1;
  logic        ecc = 1'b1;
  logic        irq_clr = 1'b0;
  logic [1:0]  ren = 2'h3;
  logic [63:0] lo = 64'h0000_8000_0000_1000;
  logic [63:0] hi = 64'h0000_80ff_0000_1fff;
  logic        wv, wr, rv, rr, irq, lv;
  logic [31:0] wa;
  logic [7:0]  wn;
  logic [3:0]  wid, wt, rid, lid, lt;
  logic [1:0]  rc;
  logic [3:0]  tag = 4'h1;
  int          fails = 0;
  int          comparisons = 0;
  dewq_checker u_dewq_checker (.clk_in(clk_in), .resetn_in(resetn_in),
    .bus32_in(bus32), .ecc_enable_in(ecc), .range_enable_in(ren),
    .range_lo_in(lo), .range_hi_in(hi), .wr_valid_in(wv),
    .wr_ready_out(wr), .wr_addr_in(wa), .wr_bytes_in(wn), .wr_id_in(wid),
    .wr_type_in(wt), .resp_valid_out(rv), .resp_ready_in(rr),
    .resp_code_out(rc), .resp_id_out(rid), .irq_clear_in(irq_clr),
    .irq_out(irq), .log_valid_out(lv), .log_id_out(lid),
    .log_type_out(lt));
  dewq_init_model u_dewq_init_model (.clk_in(clk_in), .wr_ready_in(wr),
    .resp_valid_in(rv), .resp_code_in(rc), .resp_id_in(rid),
    .wr_valid_out(wv), .wr_addr_out(wa), .wr_bytes_out(wn),
    .wr_id_out(wid), .wr_type_out(wt), .resp_ready_out(rr));
  initial
  begin
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic end_sim;
    if (fails == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic clr_irq;
    @(posedge clk_in);
    irq_clr <= 1'b1;
    @(posedge clk_in);
    irq_clr <= 1'b0;
    #1;
    chk("irq_cleared", 0, irq);
  endtask
  task automatic wr_do(input logic [31:0] a, input logic [7:0] n,
    input logic err, input int stall, input logic clr);
    logic [1:0] c;
    logic [3:0] r;
    tag = tag + 4'h1;
    u_dewq_init_model.write(a, n, tag, ~tag, stall, c, r);
    #1;
    chk("resp_code", err ? 2'h2 : 2'h0, c);
    chk("resp_id", tag, r);
    if (err)
    begin
      chk("irq", 1, irq);
      chk("log_id", tag, lid);
      chk("log_type", 4'(~tag), lt);
      chk("log_valid", 1, lv);
    end
    if (clr)
      clr_irq();
  endtask
  task automatic t_legal;
    wr_do(32'h1000, 8'h04, 1'b0, 0, 1'b0);
    wr_do(32'h1004, 8'h08, 1'b0, 2, 1'b0);
    wr_do(32'h1ffc, 8'h04, 1'b0, 0, 1'b0);
    chk("irq_legal", 0, irq);
  endtask
  task automatic t_illegal;
    logic [31:0] ad [4] = '{32'h1002, 32'h1000, 32'h1000, 32'h80ff};
    logic [7:0]  nb [4] = '{8'h04, 8'h02, 8'h00, 8'h01};
    for (int i = 0; i < 4; i++)
      wr_do(ad[i], nb[i], 1'b1, i, 1'b1);
    wr_do(32'h1001, 8'h04, 1'b1, 0, 1'b0);
    wr_do(32'h1000, 8'h04, 1'b0, 1, 1'b0);
    chk("irq_sticky", 1, irq);
    chk("log_kept", 4'(tag - 4'h1), lid);
    chk("log_type_kept", 4'(~(tag - 4'h1)), lt);
    clr_irq();
    // Clear and violation meet at one edge: set must win
    fork
      wr_do(32'h1002, 8'h04, 1'b1, 0, 1'b1);
      begin
        @(posedge clk_in);
        irq_clr <= 1'b1;
        @(posedge clk_in);
        irq_clr <= 1'b0;
      end
    join
  endtask
  task automatic t_bus16;
    @(posedge clk_in);
    bus32 <= 1'b0;
    wr_do(32'h1002, 8'h02, 1'b0, 0, 1'b0);
    wr_do(32'h1001, 8'h02, 1'b1, 0, 1'b1);
    wr_do(32'h1000, 8'h03, 1'b1, 0, 1'b1);
    @(posedge clk_in);
    bus32 <= 1'b1;
  endtask
  task automatic t_ranges;
    wr_do(32'h8100, 8'h01, 1'b0, 0, 1'b0);
    wr_do(32'h0fff, 8'h01, 1'b0, 0, 1'b0);
    chk("irq_unprot", 0, irq);
    @(posedge clk_in);
    ren <= 2'h2;
    wr_do(32'h1001, 8'h01, 1'b0, 0, 1'b0);
    chk("irq_range_off", 0, irq);
    wr_do(32'h8001, 8'h01, 1'b1, 0, 1'b1);
    @(posedge clk_in);
    ren <= 2'h3;
    ecc <= 1'b0;
    wr_do(32'h1001, 8'h01, 1'b0, 0, 1'b0);
    chk("irq_off", 0, irq);
  endtask
  initial
  begin
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    #1;
    chk("irq_reset", 0, irq);
    chk("ready_reset", 1, wr);
    chk("resp_valid_reset", 0, rv);
    chk("log_valid_reset", 0, lv);
    t_legal();
    t_illegal();
    t_bus16();
    t_ranges();
    end_sim();
  end
  initial
  begin
    #20000;
    fails++;
    end_sim();
  end
endmodule // test_dewq_checker
`default_nettype wire
